// ===== bcsc_regs.vh
`ifndef BCSC_REGS_VH
`define BCSC_REGS_VH
// ************************************************************
// Back-EMF code layout
// ************************************************************
`define BCSC_CODE_W        7
`define BCSC_SHIFT_MSB     6
`define BCSC_SHIFT_LSB     4
`define BCSC_MANT_MSB      3
`define BCSC_MANT_LSB      0
`define BCSC_CONST_W       11
`define BCSC_CODE_RST      7'h00
`define BCSC_CODE_MAX      7'h7F
`define BCSC_CONST_MAX     11'h780
// ************************************************************
// Timing
// ************************************************************
`define BCSC_CLK_HZ        20000000
`define BCSC_BRAKE_UNIT_MS 10
`define BCSC_BRAKE_UNIT_CYC (`BCSC_CLK_HZ / 1000 * `BCSC_BRAKE_UNIT_MS)
`define BCSC_PROBE_MS      5
`define BCSC_PROBE_CYC     (`BCSC_CLK_HZ / 1000 * `BCSC_PROBE_MS)
`define BCSC_ALIGN_MS      100
`define BCSC_ALIGN_CYC     (`BCSC_CLK_HZ / 1000 * `BCSC_ALIGN_MS)
`define BCSC_TMR_W         24
`endif

// ===== bcsc_bemf_decode.v
`include "bcsc_regs.vh"
module bcsc_bemf_decode (
    input  wire [6:0]  code,       // Packed back-EMF code
    output wire [10:0] weighted    // Mantissa shifted by exponent
);
    wire [2:0]  shift_exp;
    wire [3:0]  mantissa;
    assign shift_exp = code[`BCSC_SHIFT_MSB:`BCSC_SHIFT_LSB]; // see [RL14]
    assign mantissa  = code[`BCSC_MANT_MSB:`BCSC_MANT_LSB];   // see [RL14]
    // Max 15<<7 = 1920 fits 11 bits; code 1 gives 1
    assign weighted  = {7'h00, mantissa} << shift_exp; // see [RL3] see [RL4] see [RL5]
endmodule

// ===== bcsc_start_ctrl.v
`include "bcsc_regs.vh"
// Operation
// [RL1] Hold back-EMF constant as a 7-bit exponent and mantissa code.
// [RL2] Host scales measured constant by 1090 before encoding.
// [RL3] Weighted constant is mantissa shifted left by exponent.
// [RL4] Code all ones means weighted value 1920.
// [RL5] Code one means weighted value one.
// [RL6] Start handles stationary, forward and reverse rotor states.
// [RL7] Stationary rotor gets position init by one of two methods.
// [RL8] Position probe finds rotor from inductance variation.
// [RL9] Align-and-go drives a fixed phase pattern to align rotor.
// [RL10] Fast forward spin with resync enabled goes straight to closed loop.
// [RL11] Reverse drive decelerates through zero then accelerates forward.
// [RL12] Without reverse drive, wait for stop or brake, as configured.
// [RL13] Stopped reverse rotor continues with stationary start path.
// [RL14] Exponent in upper three bits, mantissa in lower four.
// [RL15] Brake only if time select nonzero; exit after low current for time.
// [RL16] Brake turns on all three low-side switches.
// [RL17] Probe used when its threshold select nonzero, else align.
// [RL18] Reverse too fast returns to speed sensing to coast down.
module bcsc_start_ctrl (
    input  wire        clk,                     // 20 MHz clock
    input  wire        rst,                     // Sync reset, active high
    input  wire        start,                   // Begin start-up
    input  wire        code_load,               // Load back-EMF code
    input  wire [6:0]  bemf_constant_code,      // Code to load
    input  wire        coast_sense_en,          // Speed sensing enabled
    input  wire        resync_en,               // Forward resync enabled
    input  wire        reverse_drive_en,        // Reverse drive enabled
    input  wire [2:0]  brake_done_time_sel,     // Brake time, 0 disables
    input  wire [3:0]  position_probe_current_sel, // 0 selects align
    input  wire [1:0]  reverse_speed_limit_sel, // Reverse speed limit
    input  wire        spin_detect,             // Async: rotor moving
    input  wire        spin_forward,            // Async: direction forward
    input  wire        speed_fast,              // Async: above resync speed
    input  wire        rev_over_limit,          // Async: reverse over limit
    input  wire        phase_current_low,       // Async: below exit current
    input  wire        probe_found,             // Async: probe located rotor
    input  wire        zero_speed,              // Async: rotor reached zero
    output reg  [6:0]  bemf_code_out,           // Held code
    output reg  [10:0] bemf_weighted,           // Weighted constant
    output reg  [2:0]  low_side_on,             // Low-side switch enables
    output reg         phases_float,            // Outputs high impedance
    output reg         probe_active,            // Position probe running
    output reg         align_active,            // Align pattern applied
    output reg         reverse_drive_active,    // Reverse drive running
    output reg         accel_active,            // Open-loop acceleration
    output reg         closed_loop,             // Closed-loop drive
    output reg  [3:0]  start_state              // Current start state
);
    // ************************************************************
    // States
    // ************************************************************
    localparam S_IDLE   = 4'h0;
    localparam S_SENSE  = 4'h1;
    localparam S_DECIDE = 4'h2;
    localparam S_REVDR  = 4'h3;
    localparam S_WAIT   = 4'h4;
    localparam S_BRAKE  = 4'h5;
    localparam S_INIT   = 4'h6;
    localparam S_PROBE  = 4'h7;
    localparam S_ALIGN  = 4'h8;
    localparam S_ACCEL  = 4'h9;
    localparam S_CLOSED = 4'hA;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    reg  [6:0] sync1_reg;
    reg  [6:0] sync2_reg;
    wire [6:0] async_in;
    assign async_in = {zero_speed, probe_found, phase_current_low,
                       rev_over_limit, speed_fast, spin_forward, spin_detect};
    always @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire s_spin  = sync2_reg[0];
    wire s_fwd   = sync2_reg[1];
    wire s_fast  = sync2_reg[2];
    wire s_rvhi  = sync2_reg[3];
    wire s_ilow  = sync2_reg[4];
    wire s_found = sync2_reg[5];
    wire s_zero  = sync2_reg[6];

    // ************************************************************
    // Back-EMF constant
    // ************************************************************
    reg  [6:0]  code_reg;
    wire [10:0] weighted;
    always @(posedge clk) begin
        if (rst)
            code_reg <= `BCSC_CODE_RST;
        else if (code_load)
            code_reg <= bemf_constant_code; // see [RL1]
    end
    bcsc_bemf_decode u_dec (
        .code     (code_reg),
        .weighted (weighted)
    );

    // ************************************************************
    // Start sequencer
    // ************************************************************
    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [23:0] tmr_reg;
    reg  [23:0] tmr_next;
    wire [23:0] brake_len;
    wire        brake_en;
    wire        probe_en;
    assign brake_en = (brake_done_time_sel != 3'h0); // see [RL15]
    assign probe_en = (position_probe_current_sel != 4'h0); // see [RL17]
    wire [31:0] brake_prod;
    // Brake time scales linearly with the select; the unit is a chosen value
    assign brake_prod = brake_done_time_sel * `BCSC_BRAKE_UNIT_CYC;
    // Seven units still fit the timer, so dropping the top bits loses nothing
    assign brake_len  = brake_prod[23:0];

    always @* begin
        state_next = state_reg;
        tmr_next   = tmr_reg;
        case (state_reg)
            S_IDLE: begin
                if (start)
                    state_next = coast_sense_en ? S_SENSE : S_INIT;
            end
            S_SENSE: begin // see [RL6]
                // Coasting with outputs floating before any decision
                if (!s_spin)
                    state_next = brake_en ? S_BRAKE : S_INIT;
                else
                    state_next = S_DECIDE;
                tmr_next = 24'h000000;
            end
            S_DECIDE: begin
                if (s_fwd) begin
                    if (resync_en && s_fast)
                        state_next = S_CLOSED; // see [RL10]
                    else
                        state_next = S_SENSE;
                end else if (s_rvhi)
                    state_next = S_SENSE; // see [RL18]
                else if (reverse_drive_en)
                    state_next = S_REVDR; // see [RL11]
                else if (brake_en)
                    state_next = S_BRAKE; // see [RL12]
                else
                    state_next = S_WAIT; // see [RL12]
            end
            S_REVDR: begin
                if (s_zero)
                    state_next = S_ACCEL; // see [RL11]
            end
            S_WAIT: begin
                if (!s_spin)
                    state_next = S_INIT; // see [RL13]
            end
            S_BRAKE: begin
                // Any current spike restarts the low-current window
                if (!s_ilow)
                    tmr_next = 24'h000000;
                else if (tmr_reg >= brake_len) // see [RL15]
                    state_next = S_INIT; // see [RL13]
                else
                    tmr_next = tmr_reg + 24'h000001;
            end
            S_INIT: begin // see [RL7]
                state_next = probe_en ? S_PROBE : S_ALIGN; // see [RL17]
                tmr_next   = 24'h000000;
            end
            S_PROBE: begin // see [RL8]
                tmr_next = tmr_reg + 24'h000001;
                if (s_found || tmr_reg == `BCSC_PROBE_CYC)
                    state_next = S_ACCEL;
            end
            S_ALIGN: begin // see [RL9]
                tmr_next = tmr_reg + 24'h000001;
                if (tmr_reg == `BCSC_ALIGN_CYC)
                    state_next = S_ACCEL;
            end
            S_ACCEL: begin
                if (s_fast)
                    state_next = S_CLOSED;
            end
            S_CLOSED: begin
                if (!start)
                    state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
        // Dropping start aborts any sequence
        if (!start)
            state_next = S_IDLE;
    end

    always @(posedge clk) begin
        if (rst) begin
            state_reg            <= S_IDLE;
            tmr_reg              <= 24'h000000;
            bemf_code_out        <= `BCSC_CODE_RST;
            bemf_weighted        <= 11'h000;
            low_side_on          <= 3'h0;
            phases_float         <= 1'b1;
            probe_active         <= 1'b0;
            align_active         <= 1'b0;
            reverse_drive_active <= 1'b0;
            accel_active         <= 1'b0;
            closed_loop          <= 1'b0;
            start_state          <= S_IDLE;
        end else begin
            state_reg            <= state_next;
            tmr_reg              <= tmr_next;
            bemf_code_out        <= code_reg;
            bemf_weighted        <= weighted; // see [RL3]
            low_side_on          <= (state_next == S_BRAKE) ? 3'h7 : 3'h0; // see [RL16]
            phases_float         <= (state_next == S_IDLE) ||
                                    (state_next == S_SENSE) ||
                                    (state_next == S_DECIDE) ||
                                    (state_next == S_WAIT) ||
                                    (state_next == S_INIT);
            probe_active         <= (state_next == S_PROBE);
            align_active         <= (state_next == S_ALIGN);
            reverse_drive_active <= (state_next == S_REVDR);
            accel_active         <= (state_next == S_ACCEL);
            closed_loop          <= (state_next == S_CLOSED);
            start_state          <= state_next;
        end
    end
endmodule

// ===== bcsc_motor_model.sv
module bcsc_motor_model (
    input  wire logic       clk,                  // Bench clock
    input  wire logic       rst,                  // Sync reset
    input  wire logic [1:0] motion,               // 0 still, 1 fwd, 2 rev
    input  wire logic       probe_active,         // Probe pulses applied
    input  wire logic       reverse_drive_active, // Reverse drive applied
    input  wire logic       accel_active,         // Open-loop drive applied
    input  wire logic [2:0] low_side_on,          // Low-side switches
    output logic            spin_detect,          // Rotor moving
    output logic            spin_forward,         // Direction forward
    output logic            speed_fast,           // Above resync speed
    output logic            probe_found,          // Probe located rotor
    output logic            zero_speed,           // Rotor reached zero
    output logic            phase_current_low     // Winding current decayed
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    logic       busy;
    // Windings respond only after being driven for a while, never at once
    assign busy = probe_active | reverse_drive_active | accel_active
                | (low_side_on == 3'h7);
    always @(posedge clk) begin
        if (rst || !busy)
            cnt_reg <= 4'h0;
        else if (cnt_reg != 4'hF)
            cnt_reg <= cnt_reg + 4'h1;
    end
    assign spin_detect = motion != 2'h0;
    assign spin_forward = motion == 2'h1;
    assign speed_fast = spin_forward | (accel_active & (cnt_reg > 4'h8));
    assign probe_found = probe_active & (cnt_reg > 4'h8);
    assign zero_speed = reverse_drive_active & (cnt_reg > 4'h8);
    assign phase_current_low = cnt_reg > 4'h4;
endmodule

// ===== bcsc_start_ctrl_asserts.sv
module bcsc_start_ctrl_asserts (
    input wire logic        clk,                        // Clock
    input wire logic        rst,                        // Sync reset
    input wire logic        start,                      // Start-up request
    input wire logic        code_load,                  // Code load strobe
    input wire logic [6:0]  bemf_constant_code,         // Code to load
    input wire logic        coast_sense_en,             // Speed sensing on
    input wire logic [2:0]  brake_done_time_sel,        // Brake time select
    input wire logic [3:0]  position_probe_current_sel, // Probe select
    input wire logic [6:0]  bemf_code_out,              // Held code
    input wire logic [10:0] bemf_weighted,              // Weighted constant
    input wire logic [2:0]  low_side_on,                // Low-side enables
    input wire logic        phases_float,               // Outputs floating
    input wire logic        closed_loop,                // Closed-loop drive
    input wire logic [3:0]  start_state                 // Start state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_code_held: assert property (code_load ##1 !code_load |=>
        bemf_code_out == $past(bemf_constant_code, 2)) else $error("code");
    a_weight_shift: assert property (code_load ##1 !code_load |=>
        bemf_weighted == ({7'h00, $past(bemf_constant_code[3:0], 2)}
        << $past(bemf_constant_code[6:4], 2))) else $error("weight");
    a_brake_lows: assert property (start_state == 4'h5 |->
        low_side_on == 3'h7 && !phases_float) else $error("brake lows");
    a_lows_off: assert property (start_state != 4'h5 |->
        low_side_on == 3'h0) else $error("lows on");
    a_brake_enable: assert property ($rose(start_state == 4'h5) |->
        $past(brake_done_time_sel) != 3'h0) else $error("brake sel");
    a_probe_pick: assert property (start_state == 4'h6 && start &&
        position_probe_current_sel != 4'h0 |=> start_state == 4'h7)
        else $error("probe");
    a_align_pick: assert property (start_state == 4'h6 && start &&
        position_probe_current_sel == 4'h0 |=> start_state == 4'h8)
        else $error("align");
    a_idle_exit: assert property (start_state == 4'h0 && start
        && !coast_sense_en |=> start_state == 4'h6) else $error("idle");
    a_stop_idle: assert property (!start |=> start_state == 4'h0
        && phases_float ##1 (start_state == 4'h0 || start))
        else $error("stop");
    a_closed_drive: assert property (start_state == 4'hA |->
        closed_loop && !phases_float) else $error("closed");
endmodule
bind bcsc_start_ctrl bcsc_start_ctrl_asserts u_bcsc_start_ctrl_asserts (
    .clk                        (clk),
    .rst                        (rst),
    .start                      (start),
    .code_load                  (code_load),
    .bemf_constant_code         (bemf_constant_code),
    .coast_sense_en             (coast_sense_en),
    .brake_done_time_sel        (brake_done_time_sel),
    .position_probe_current_sel (position_probe_current_sel),
    .bemf_code_out              (bemf_code_out),
    .bemf_weighted              (bemf_weighted),
    .low_side_on                (low_side_on),
    .phases_float               (phases_float),
    .closed_loop                (closed_loop),
    .start_state                (start_state)
);

// ===== bcsc_start_ctrl_tb.sv
module bcsc_start_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, start, code_load, cs, rs, rd, ov, sd, sf, fast, pf, zs, pcl;
    logic [6:0] code, code_o;
    logic [2:0] bs, lows;
    logic [3:0] ps, st;
    logic [1:0] mot;
    logic [10:0] wt;
    logic flt, pa, aa, ra, ca, cl;
    int mismatches = 0, n_tests = 0;
    bcsc_start_ctrl u_bcsc_start_ctrl (.clk(clk), .rst(rst), .start(start),
        .code_load(code_load), .bemf_constant_code(code), .coast_sense_en(cs),
        .resync_en(rs), .reverse_drive_en(rd), .brake_done_time_sel(bs),
        .position_probe_current_sel(ps), .reverse_speed_limit_sel(2'h1),
        .spin_detect(sd), .spin_forward(sf), .speed_fast(fast),
        .rev_over_limit(ov), .phase_current_low(pcl), .probe_found(pf),
        .zero_speed(zs), .bemf_code_out(code_o), .bemf_weighted(wt),
        .low_side_on(lows), .phases_float(flt), .probe_active(pa),
        .align_active(aa), .reverse_drive_active(ra), .accel_active(ca),
        .closed_loop(cl), .start_state(st));
    bcsc_motor_model u_bcsc_motor_model (.clk(clk), .rst(rst), .motion(mot),
        .probe_active(pa), .reverse_drive_active(ra), .accel_active(ca),
        .low_side_on(lows), .spin_detect(sd), .spin_forward(sf),
        .speed_fast(fast), .probe_found(pf), .zero_speed(zs),
        .phase_current_low(pcl));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task give_verdict;
        $display("mismatches %0d tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // Every edge is inspected, so one-cycle states are not missed
    task wait_st(input logic [3:0] s);
        int i;
        i = 0;
        while (st !== s && i < 300) begin
            @(posedge clk);
            #1;
            i++;
        end
        check(st, s);
        if (st !== s)
            give_verdict;
    endtask
    task load(input logic [6:0] c, input logic [10:0] w);
        @(posedge clk);
        code_load <= 1'b1;
        code <= c;
        @(posedge clk);
        code_load <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(wt, w);
        check(code_o, c);
    endtask
    task run(input logic [1:0] m, input logic [3:0] f, input logic [2:0] b,
             input logic [3:0] p);
        @(posedge clk);
        mot <= m;
        {cs, rs, rd, ov} <= f;
        bs <= b;
        ps <= p;
        // The rotor motion is set before start-up; let the synchronisers see it
        repeat (3) @(posedge clk);
        start <= 1'b1;
    endtask
    task stop;
        @(posedge clk);
        start <= 1'b0;
        mot <= 2'h0;
        wait_st(4'h0);
    endtask
    initial begin
        {rst, start, code_load, cs, rs, rd, ov} = 7'h40;
        {code, bs, ps, mot} = 16'h0000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({lows, flt, st}, 11'h010);
        load(7'h7F, 11'h780);
        load(7'h01, 11'h001);
        load(7'h5A, 11'h140);
        load(7'h2C, 11'h030);
        run(2'h0, 4'h0, 3'h0, 4'h1);
        wait_st(4'h6);
        wait_st(4'h7);
        check(pa, 1'b1);
        wait_st(4'h9);
        check(ca, 1'b1);
        wait_st(4'hA);
        stop;
        run(2'h0, 4'h0, 3'h0, 4'h0);
        wait_st(4'h8);
        check({aa, flt}, 2'h2);
        stop;
        run(2'h0, 4'h8, 3'h1, 4'h1);
        wait_st(4'h1);
        wait_st(4'h5);
        check(lows, 3'h7);
        stop;
        run(2'h1, 4'hC, 3'h0, 4'h1);
        wait_st(4'h2);
        wait_st(4'hA);
        check(cl, 1'b1);
        stop;
        run(2'h1, 4'h8, 3'h0, 4'h1);
        wait_st(4'h2);
        wait_st(4'h1);
        stop;
        run(2'h2, 4'h9, 3'h1, 4'h1);
        wait_st(4'h2);
        wait_st(4'h1);
        stop;
        run(2'h2, 4'hA, 3'h1, 4'h1);
        wait_st(4'h3);
        check(ra, 1'b1);
        wait_st(4'h9);
        check(ca, 1'b1);
        stop;
        run(2'h2, 4'h8, 3'h1, 4'h1);
        wait_st(4'h5);
        check(lows, 3'h7);
        stop;
        run(2'h2, 4'h8, 3'h0, 4'h1);
        wait_st(4'h4);
        @(posedge clk);
        mot <= 2'h0;
        wait_st(4'h6);
        stop;
        give_verdict;
    end
endmodule
